// file: rtl/ldcf_link_if.sv
// carrier between the serial receiver and the register core
`timescale 1ns/1ps
`default_nettype none
interface ldcf_link_if;
    logic [23:0] frame_word;
    logic frame_valid;
    logic frame_bad;
    logic frame_start;
    logic [23:0] tx_word;
    logic tx_enable;
    modport rx (
        output frame_word, frame_valid, frame_bad, frame_start,
        input tx_word, tx_enable
    );
    modport core (
        input frame_word, frame_valid, frame_bad, frame_start,
        output tx_word, tx_enable
    );
endinterface
`default_nettype wire

// file: rtl/ldcf_pkg.sv
// constants and types of the loop converter configuration and fault registers
package ldcf_pkg;
    // serial frame: read flag, 7-bit address, 16-bit data, msb first
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int FRM_RD_POS = 23;
    localparam int FRM_ADDR_HI = 22;
    localparam int FRM_ADDR_LO = 16;
    localparam int FRM_DATA_HI = 15;
    localparam logic [6:0] ADDR_NOP = 7'h00;
    localparam logic [6:0] ADDR_CONFIG = 7'h02;
    localparam logic [6:0] ADDR_FLAGS = 7'h05;
    // operating_configuration fields
    localparam int CFG_TMO_HI = 14;
    localparam int CFG_TMO_LO = 12;
    localparam int CFG_WD_OFF = 11;
    localparam int CFG_ALARM_OFF = 10;
    localparam int CFG_AUTO_OFF = 9;
    localparam int CFG_MIN_CUR = 8;
    localparam int CFG_MON_TEMP = 7;
    localparam int CFG_MON_EN = 6;
    localparam int CFG_REF_PD = 5;
    localparam int CFG_LOOP_SUPPLY_SENSE_ALERT = 4;
    localparam logic [15:0] CFG_RESET = 16'h3000;
    localparam logic [15:0] CFG_WMASK = 16'h7ff0;
    // fault_condition_flags fields
    localparam int FLT_LINK = 15;
    localparam int FLT_FRAME = 14;
    localparam int FLT_OVER = 13;
    localparam int FLT_UNDER = 12;
    localparam int FLT_T140 = 11;
    localparam int FLT_T100 = 10;
    localparam int FLT_V6 = 9;
    localparam int FLT_V12 = 8;
    localparam int FLT_VAL_HI = 7;
    // synchronised status vector layout
    localparam int ST_BITS = 15;
    localparam int ST_DIR = 14;
    localparam int ST_OVER = 13;
    localparam int ST_UNDER = 12;
    localparam int ST_T140 = 11;
    localparam int ST_T100 = 10;
    localparam int ST_V6 = 9;
    localparam int ST_V12 = 8;
    localparam int ST_VAL_HI = 7;
    // timing: one watchdog tick per millisecond
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [16:0] TICK_ONE = 17'h00001;
    localparam logic [12:0] MS_ONE = 13'h0001;
    // watchdog periods in ms: 50 ms, 100 ms, 500 ms, 1 sec, 2, 3, 4, 5 sec
    localparam logic [12:0] WD_TIMEOUT_MS [8] = '{13'h0032, 13'h0064, 13'h01f4,
        13'h03e8, 13'h07d0, 13'h0bb8, 13'h0fa0, 13'h1388};
    typedef enum logic [1:0] {
        WD_OFF = 2'b00,
        WD_RUN = 2'b01,
        WD_EXPIRED = 2'b11
    } ldcf_wd_state_type;
endpackage

// file: rtl/ldcf_serial_rx.sv
// serial link receiver: pin synchronisers, frame shift in and readback shift out
`timescale 1ns/1ps
`default_nettype none
module ldcf_serial_rx (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic sync_n_in,
    input wire logic sclk_in,
    input wire logic sdin_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    ldcf_link_if.rx link
);
    import ldcf_pkg::*;

    logic [2:0] s1_ff, s2_ff, s3_ff;
    logic [23:0] rx_ff, nxt_rx;
    logic [23:0] tx_ff, nxt_tx;
    logic [4:0] cnt_ff, nxt_cnt;
    logic oe_ff, nxt_oe;
    logic sdo_ff, nxt_sdo;
    logic valid_ff, nxt_valid, bad_ff, nxt_bad, start_ff, nxt_start;
    logic sync_fall, sync_rise, sclk_rise, sclk_fall, in_frame;

    // two-stage synchronisers plus a history stage for edge finding
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_ff <= 3'h7;
            s2_ff <= 3'h7;
            s3_ff <= 3'h7;
        end else begin
            s1_ff <= {sync_n_in, sclk_in, sdin_in};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign sync_fall = s3_ff[2] & ~s2_ff[2];
    assign sync_rise = ~s3_ff[2] & s2_ff[2];
    assign in_frame = ~s2_ff[2];
    assign sclk_rise = in_frame & ~s3_ff[1] & s2_ff[1];
    assign sclk_fall = in_frame & s3_ff[1] & ~s2_ff[1];

    // shift in on rising sclk, shift out on falling sclk
    always_comb begin
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        nxt_cnt = cnt_ff;
        nxt_oe = oe_ff;
        nxt_sdo = sdo_ff;
        nxt_valid = 1'b0;
        nxt_bad = 1'b0;
        nxt_start = 1'b0;
        if (sync_fall) begin
            nxt_start = 1'b1;
            nxt_cnt = 5'h00;
            nxt_tx = {link.tx_word[22:0], 1'b0};
            nxt_sdo = link.tx_word[23];
            nxt_oe = link.tx_enable;
        end else if (sync_rise) begin
            nxt_oe = 1'b0;
            nxt_sdo = 1'b0;
            nxt_valid = (cnt_ff == FRAME_BITS);
            nxt_bad = (cnt_ff != FRAME_BITS);
        end else begin
            if (sclk_rise) begin
                nxt_rx = {rx_ff[22:0], s2_ff[0]};
                if (cnt_ff != 5'h1f) begin
                    nxt_cnt = cnt_ff + 5'h01;
                end
            end
            if (sclk_fall) begin
                nxt_sdo = tx_ff[23];
                nxt_tx = {tx_ff[22:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_ff <= 24'h000000;
            tx_ff <= 24'h000000;
            cnt_ff <= 5'h00;
            oe_ff <= 1'b0;
            sdo_ff <= 1'b0;
            valid_ff <= 1'b0;
            bad_ff <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            cnt_ff <= nxt_cnt;
            oe_ff <= nxt_oe;
            sdo_ff <= nxt_sdo;
            valid_ff <= nxt_valid;
            bad_ff <= nxt_bad;
            start_ff <= nxt_start;
        end
    end

    assign link.frame_word = rx_ff;
    assign link.frame_valid = valid_ff;
    assign link.frame_bad = bad_ff;
    assign link.frame_start = start_ff;
    assign sdo_out = sdo_ff;
    assign sdo_oe_out = oe_ff;
endmodule
`default_nettype wire

// file: rtl/ldcf_top.sv
// configuration register, fault flags, link watchdog and loop control outputs
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - auto readback off: no fault shift-out
// RULE2 - link fault forces alarm unless disabled
// RULE3 - link fault always sets flag and pin
// RULE4 - watchdog expiry declares a link fault
// RULE5 - min-current bit drives loop to minimum
// RULE6 - monitor select: loop voltage or temperature
// RULE7 - reference power-down bit, default powered
// RULE8 - loop voltage alert gates fault pin; CFG_WMASK keeps the alert bit writable, so V6 reaches the pin while it is set
// RULE9 - fault register read-only, writes ignored
// RULE10 - config write or no-op restarts watchdog
// RULE11 - alarm direction follows direction pin
// RULE12 - conversions only while monitor enabled
module ldcf_top #(
    parameter int TICK_CYCLES = ldcf_pkg::TICK_CYCLES_DEF
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic SYNC_N_IN,
    input wire logic SCLK_IN,
    input wire logic SDIN_IN,
    output logic SDO_OUT,
    output logic SDO_OE_OUT,
    input wire logic ALARM_DIR_UP_IN,
    input wire logic LOOP_OVER_IN,
    input wire logic LOOP_UNDER_IN,
    input wire logic TEMP_140_IN,
    input wire logic TEMP_100_IN,
    input wire logic LOOP_SUPPLY_SENSE_LOW_6_IN,
    input wire logic LOOP_SUPPLY_SENSE_LOW_12_IN,
    input wire logic [7:0] MONITOR_VALUE_IN,
    output logic FAULT_OUT,
    output logic ALARM_CURRENT_OUT,
    output logic ALARM_UPSCALE_OUT,
    output logic MIN_CURRENT_OUT,
    output logic MONITOR_SELECT_TEMP_OUT,
    output logic MONITOR_START_OUT,
    output logic REF_POWER_DOWN_OUT
);
    import ldcf_pkg::*;

    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    ldcf_link_if link ();

    logic [ST_BITS-1:0] st_raw, st1_ff, st_ff;
    logic [15:0] cfg_ff, nxt_cfg;
    logic [15:0] flags;
    logic link_flt_ff, nxt_link_flt;
    logic frame_flt_ff, nxt_frame_flt;
    logic pend_ff, nxt_pend;
    logic [6:0] pend_addr_ff, nxt_pend_addr;
    ldcf_wd_state_type wd_ff, nxt_wd;
    logic [12:0] ms_ff, nxt_ms;
    logic [16:0] tick_ff, nxt_tick;
    logic fault_ff, nxt_fault;
    logic alarm_ff, nxt_alarm;
    logic up_ff, nxt_up;
    logic min_ff, nxt_min;
    logic sel_ff, nxt_sel;
    logic start_ff, nxt_start;
    logic refpd_ff, nxt_refpd;
    logic tick, wd_restart, is_write, wd_expire;
    logic [6:0] fr_addr;

    // serial link front end
    ldcf_serial_rx u_rx (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .sync_n_in(SYNC_N_IN),
        .sclk_in(SCLK_IN),
        .sdin_in(SDIN_IN),
        .sdo_out(SDO_OUT),
        .sdo_oe_out(SDO_OE_OUT),
        .link(link)
    );

    // status pins pass two flip-flops each
    assign st_raw = {ALARM_DIR_UP_IN, LOOP_OVER_IN, LOOP_UNDER_IN, TEMP_140_IN,
        TEMP_100_IN, LOOP_SUPPLY_SENSE_LOW_6_IN, LOOP_SUPPLY_SENSE_LOW_12_IN, MONITOR_VALUE_IN};
    genvar gi;
    generate
        for (gi = 0; gi < ST_BITS; gi++) begin : g_sync
            always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
                if (!RESET_N_IN) begin
                    st1_ff[gi] <= 1'b0;
                    st_ff[gi] <= 1'b0;
                end else begin
                    st1_ff[gi] <= st_raw[gi];
                    st_ff[gi] <= st1_ff[gi];
                end
            end
        end
    endgenerate

    // fault register view, live comparator bits plus sticky link bits
    always_comb begin
        flags = 16'h0000;
        flags[FLT_LINK] = link_flt_ff;
        flags[FLT_FRAME] = frame_flt_ff;
        flags[FLT_OVER] = st_ff[ST_OVER];
        flags[FLT_UNDER] = st_ff[ST_UNDER];
        flags[FLT_T140] = st_ff[ST_T140];
        flags[FLT_T100] = st_ff[ST_T100];
        flags[FLT_V6] = st_ff[ST_V6];
        flags[FLT_V12] = st_ff[ST_V12];
        flags[FLT_VAL_HI:0] = st_ff[ST_VAL_HI:0];
    end

    // readback word for the next frame
    always_comb begin
        link.tx_word = {1'b0, ADDR_FLAGS, flags};
        if (pend_ff && pend_addr_ff == ADDR_CONFIG) begin
            link.tx_word = {1'b1, ADDR_CONFIG, cfg_ff};
        end else if (pend_ff) begin
            link.tx_word = {1'b1, pend_addr_ff, flags};
        end
        link.tx_enable = pend_ff | ~cfg_ff[CFG_AUTO_OFF]; // RULE1
    end

    // frame decode
    assign fr_addr = link.frame_word[FRM_ADDR_HI:FRM_ADDR_LO];
    assign is_write = link.frame_valid & ~link.frame_word[FRM_RD_POS];
    assign wd_restart = is_write & (fr_addr == ADDR_CONFIG || fr_addr == ADDR_NOP); // RULE10
    assign tick = (tick_ff == TICK_LAST);
    assign wd_expire = (wd_ff == WD_RUN) && tick
        && (ms_ff >= WD_TIMEOUT_MS[cfg_ff[CFG_TMO_HI:CFG_TMO_LO]] - MS_ONE); // RULE4

    // register file, pending readback and sticky link flags
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_pend = pend_ff;
        nxt_pend_addr = pend_addr_ff;
        nxt_link_flt = link_flt_ff;
        nxt_frame_flt = frame_flt_ff;
        // only the configuration word takes writes, flag writes fall through
        if (is_write && fr_addr == ADDR_CONFIG) begin // RULE9
            nxt_cfg = link.frame_word[FRM_DATA_HI:0] & CFG_WMASK;
        end
        if (link.frame_start) begin
            nxt_pend = 1'b0;
            if (pend_ff && pend_addr_ff == ADDR_FLAGS) begin
                nxt_link_flt = 1'b0;
                nxt_frame_flt = 1'b0;
            end
        end
        if (link.frame_valid && link.frame_word[FRM_RD_POS]) begin
            nxt_pend = 1'b1;
            nxt_pend_addr = fr_addr;
        end
        // setting wins over a clear in the same cycle
        if (wd_expire) begin
            nxt_link_flt = 1'b1; // RULE3
        end
        if (link.frame_bad) begin
            nxt_frame_flt = 1'b1;
        end
    end

    // watchdog: ms tick prescaler and timeout counter
    always_comb begin
        nxt_wd = wd_ff;
        nxt_ms = ms_ff;
        nxt_tick = tick ? 17'h00000 : tick_ff + TICK_ONE;
        unique case (wd_ff)
            WD_OFF: begin
                nxt_ms = 13'h0000;
                if (!cfg_ff[CFG_WD_OFF]) begin
                    nxt_wd = WD_RUN;
                end
            end
            WD_RUN: begin
                if (wd_expire) begin
                    nxt_wd = WD_EXPIRED; // RULE4
                end else if (tick) begin
                    nxt_ms = ms_ff + MS_ONE;
                end
            end
            WD_EXPIRED: begin
                nxt_ms = 13'h0000;
            end
            default: begin
                nxt_wd = WD_OFF;
            end
        endcase
        if (wd_restart) begin
            nxt_ms = 13'h0000; // RULE10
            nxt_wd = WD_RUN;
        end
        if (cfg_ff[CFG_WD_OFF] || (is_write && fr_addr == ADDR_CONFIG
                && link.frame_word[CFG_WD_OFF])) begin
            nxt_wd = WD_OFF;
        end
    end

    // loop control and monitor outputs
    always_comb begin
        nxt_fault = link_flt_ff | frame_flt_ff | st_ff[ST_OVER] | st_ff[ST_UNDER]
            | st_ff[ST_T140] | (st_ff[ST_V6] & cfg_ff[CFG_LOOP_SUPPLY_SENSE_ALERT]); // RULE3 RULE8
        nxt_alarm = link_flt_ff & ~cfg_ff[CFG_ALARM_OFF]; // RULE2
        nxt_up = st_ff[ST_DIR]; // RULE11
        nxt_min = cfg_ff[CFG_MIN_CUR] & ~nxt_alarm; // RULE5
        nxt_sel = cfg_ff[CFG_MON_TEMP]; // RULE6
        nxt_start = tick & cfg_ff[CFG_MON_EN]; // RULE12
        nxt_refpd = cfg_ff[CFG_REF_PD]; // RULE7
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            cfg_ff <= CFG_RESET;
            pend_ff <= 1'b0;
            pend_addr_ff <= ADDR_NOP;
            link_flt_ff <= 1'b0;
            frame_flt_ff <= 1'b0;
            wd_ff <= WD_OFF;
            ms_ff <= 13'h0000;
            tick_ff <= 17'h00000;
            fault_ff <= 1'b0;
            alarm_ff <= 1'b0;
            up_ff <= 1'b0;
            min_ff <= 1'b0;
            sel_ff <= 1'b0;
            start_ff <= 1'b0;
            refpd_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            pend_ff <= nxt_pend;
            pend_addr_ff <= nxt_pend_addr;
            link_flt_ff <= nxt_link_flt;
            frame_flt_ff <= nxt_frame_flt;
            wd_ff <= nxt_wd;
            ms_ff <= nxt_ms;
            tick_ff <= nxt_tick;
            fault_ff <= nxt_fault;
            alarm_ff <= nxt_alarm;
            up_ff <= nxt_up;
            min_ff <= nxt_min;
            sel_ff <= nxt_sel;
            start_ff <= nxt_start;
            refpd_ff <= nxt_refpd;
        end
    end

    assign FAULT_OUT = fault_ff;
    assign ALARM_CURRENT_OUT = alarm_ff;
    assign ALARM_UPSCALE_OUT = up_ff;
    assign MIN_CURRENT_OUT = min_ff;
    assign MONITOR_SELECT_TEMP_OUT = sel_ff;
    assign MONITOR_START_OUT = start_ff;
    assign REF_POWER_DOWN_OUT = refpd_ff;
endmodule
`default_nettype wire

// file: verif/ldcf_asserts.sv
// pin-level checks for the loop converter configuration and fault block
`timescale 1ns/1ps
`default_nettype none
module ldcf_asserts #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic SYNC_N_IN,
    input wire logic SDO_OE_OUT,
    input wire logic ALARM_DIR_UP_IN,
    input wire logic FAULT_OUT,
    input wire logic ALARM_CURRENT_OUT,
    input wire logic ALARM_UPSCALE_OUT,
    input wire logic MIN_CURRENT_OUT,
    input wire logic MONITOR_SELECT_TEMP_OUT,
    input wire logic MONITOR_START_OUT,
    input wire logic REF_POWER_DOWN_OUT
);
    localparam int WD_MIN = 49 * TICK_CYCLES;
    logic [31:0] run_ff;
    logic [31:0] nxt_run;
    // cycles since reset release, saturating
    always_comb begin
        nxt_run = (run_ff == 32'hffffffff) ? run_ff : run_ff + 32'h1;
    end
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            run_ff <= 32'h0;
        end else begin
            run_ff <= nxt_run;
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // link quiet or framing for a while
    sequence s_link_idle; SYNC_N_IN [*8]; endsequence
    sequence s_link_busy; !SYNC_N_IN [*8]; endsequence
    property p_alarm_fault; ALARM_CURRENT_OUT |-> FAULT_OUT; endproperty
    a_alarm_fault: assert property (p_alarm_fault)
        else $error("alarm current without fault pin");
    property p_dir_up; ALARM_DIR_UP_IN [*5] |-> ALARM_UPSCALE_OUT; endproperty
    a_dir_up: assert property (p_dir_up)
        else $error("alarm direction not upscale");
    property p_dir_dn; !ALARM_DIR_UP_IN [*5] |-> !ALARM_UPSCALE_OUT; endproperty
    a_dir_dn: assert property (p_dir_dn)
        else $error("alarm direction not downscale");
    property p_min_excl; ALARM_CURRENT_OUT |-> !MIN_CURRENT_OUT; endproperty
    a_min_excl: assert property (p_min_excl)
        else $error("minimum current during alarm");
    property p_start_pulse; MONITOR_START_OUT |=> !MONITOR_START_OUT [*8]; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("conversion start too close");
    property p_ref_stable; s_link_busy |-> $stable(REF_POWER_DOWN_OUT); endproperty
    a_ref_stable: assert property (p_ref_stable)
        else $error("reference control moved mid frame");
    property p_sel_stable; s_link_busy |-> $stable(MONITOR_SELECT_TEMP_OUT); endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("monitor select moved mid frame");
    property p_oe_idle; s_link_idle |-> !SDO_OE_OUT; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("serial output driven outside frame");
    property p_wd_delay; $rose(ALARM_CURRENT_OUT) |-> run_ff >= WD_MIN; endproperty
    a_wd_delay: assert property (p_wd_delay)
        else $error("alarm before shortest timeout");
    property p_alarm_hold; s_link_idle ##0 ALARM_CURRENT_OUT |=> ALARM_CURRENT_OUT; endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm dropped with link idle");
endmodule
`default_nettype wire

// file: verif/ldcf_host_model.sv
// host serial master model for the loop converter link
`timescale 1ns/1ps
`default_nettype none
module ldcf_host_model (
    output logic sync_n_out,
    output logic sclk_out,
    output logic sdin_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in
);
    logic oe_seen;
    // idle link: not selected, clock still
    initial begin
        sync_n_out = 1'b1;
        sclk_out = 1'b0;
        sdin_out = 1'b0;
        oe_seen = 1'b0;
    end
    // one 24-bit frame, msb first, 125 ns link clock
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        oe_seen = 1'b0;
        #3.7 sync_n_out = 1'b0;
        #60;
        for (int i = 23; i >= 0; i--) begin
            sdin_out = w[i];
            #62.5 sclk_out = 1'b1;
            r[i] = sdo_in;
            oe_seen = oe_seen | sdo_oe_in;
            #62.5 sclk_out = 1'b0;
        end
        #60 sync_n_out = 1'b1;
        sdin_out = ~sdin_out; // no stale data after release
        #80;
    endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the loop converter configuration and fault block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ldcf_pkg::*;
    localparam int TICKS = 10;
    logic clk;
    logic rst_n;
    logic dir_up;
    logic [5:0] stat;
    logic [7:0] mon;
    logic [23:0] rd;
    logic quiet;
    int waited;
    wire sync_n, sclk, sdin, sdo, sdo_oe;
    wire fault, alarm, alarm_up, min_cur, mon_temp, mon_start, ref_pd;
    int error_cnt = 0;
    int n_checks = 0;
    ldcf_top #(.TICK_CYCLES(TICKS)) u_ldcf_top (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .SYNC_N_IN(sync_n), .SCLK_IN(sclk),
        .SDIN_IN(sdin), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .ALARM_DIR_UP_IN(dir_up),
        .LOOP_OVER_IN(stat[5]), .LOOP_UNDER_IN(stat[4]), .TEMP_140_IN(stat[3]),
        .TEMP_100_IN(stat[2]), .LOOP_SUPPLY_SENSE_LOW_6_IN(stat[1]), .LOOP_SUPPLY_SENSE_LOW_12_IN(stat[0]),
        .MONITOR_VALUE_IN(mon), .FAULT_OUT(fault), .ALARM_CURRENT_OUT(alarm),
        .ALARM_UPSCALE_OUT(alarm_up), .MIN_CURRENT_OUT(min_cur),
        .MONITOR_SELECT_TEMP_OUT(mon_temp), .MONITOR_START_OUT(mon_start),
        .REF_POWER_DOWN_OUT(ref_pd));
    ldcf_host_model u_host (.sync_n_out(sync_n), .sclk_out(sclk), .sdin_out(sdin),
        .sdo_in(sdo), .sdo_oe_in(sdo_oe));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // settle n edges, then sample away from the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        u_host.xfer({1'b0, a, d}, rd);
        cyc(8);
    endtask
    // read request, then a no-op frame carries the answer
    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        u_host.xfer({1'b1, a, 16'h0000}, rd);
        u_host.xfer({1'b0, ADDR_NOP, 16'h0000}, rd);
        cyc(8);
        chk(rd, {1'b1, a, exp});
    endtask
    task automatic wait_for(input bit pick, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk);
            if ((pick ? mon_start : fault) === 1'b1) break;
        end
        waited = i;
        if (i == lim) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, i, lim);
            stop_test();
        end
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        dir_up = 1'b1;
        stat = 6'h00;
        mon = 8'h5a;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        cyc(4);
        chk({18'h0, fault, alarm, min_cur, mon_temp, ref_pd, alarm_up}, 24'h1);
        rdchk(ADDR_CONFIG, CFG_RESET);
        wr(ADDR_CONFIG, CFG_RESET);
        chk(rd, {1'b0, ADDR_FLAGS, 16'h005a});
        wr(ADDR_CONFIG, 16'hffff);
        rdchk(ADDR_CONFIG, CFG_WMASK);
        chk({21'h0, min_cur, mon_temp, ref_pd}, 24'h7);
        wait_for(1'b1, 4 * TICKS);
        cyc(0);
        chk({23'h0, mon_start}, 24'h0);
        @(posedge clk) stat <= 6'h02;
        cyc(6);
        chk({23'h0, fault}, 24'h1);
        wr(ADDR_CONFIG, 16'h3200);
        chk({22'h0, u_host.oe_seen, fault}, 24'h0);
        chk({21'h0, min_cur, mon_temp, ref_pd}, 24'h0);
        // monitor disabled: no conversion start over several ticks
        quiet = 1'b0;
        for (int k = 0; k < 3 * TICKS; k++) begin
            @(negedge clk);
            quiet = quiet | mon_start;
        end
        chk({23'h0, quiet}, 24'h0);
        rdchk(ADDR_FLAGS, 16'h025a);
        @(posedge clk) stat <= 6'h00;
        wr(ADDR_FLAGS, 16'hffff);
        rdchk(ADDR_FLAGS, 16'h005a);
        wr(ADDR_CONFIG, 16'h1100);
        repeat (4) wr(ADDR_NOP, 16'h0000);
        chk({22'h0, fault, alarm}, 24'h0);
        @(posedge clk) dir_up <= 1'b0;
        wait_for(1'b0, 1200);
        chk({23'h0, waited > 95 * TICKS}, 24'h1);
        cyc(4);
        chk({20'h0, fault, alarm, alarm_up, min_cur}, 24'hc);
        rdchk(ADDR_FLAGS, 16'h805a);
        chk({22'h0, fault, alarm}, 24'h0);
        wr(ADDR_CONFIG, 16'h0500);
        wait_for(1'b0, 700);
        chk({23'h0, waited > 45 * TICKS}, 24'h1);
        cyc(4);
        chk({21'h0, fault, alarm, min_cur}, 24'h5);
        stop_test();
    end
endmodule
bind ldcf_top ldcf_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_ldcf_asserts (.CLK_IN,
    .RESET_N_IN, .SYNC_N_IN, .SDO_OE_OUT, .ALARM_DIR_UP_IN, .FAULT_OUT,
    .ALARM_CURRENT_OUT, .ALARM_UPSCALE_OUT, .MIN_CURRENT_OUT,
    .MONITOR_SELECT_TEMP_OUT, .MONITOR_START_OUT, .REF_POWER_DOWN_OUT);
`default_nettype wire
